// ### inc/dcs_pkg.sv
// Purpose: Constants for the disk command and status unit
// Assumes: Six-byte command strings, 256-byte defect-map sectors
// Notes: Unit, retry and valid bit positions and timing counts live here; other command fields are decoded in dcs_unit
package dcs_pkg;
  localparam logic [7:0] OP_TEST_READY = 8'h00;
  localparam logic [7:0] OP_RECAL = 8'h01;
  localparam logic [7:0] OP_SENSE = 8'h03;
  localparam logic [7:0] OP_FORMAT_DRIVE = 8'h04;
  localparam logic [7:0] OP_CHECK_FORMAT = 8'h05;
  localparam logic [7:0] OP_FORMAT_TRACK = 8'h06;
  localparam int UNIT_HI = 6;
  localparam int UNIT_LO = 5;
  localparam int RETRY_BIT = 7;
  localparam int VALID_BIT = 7;
  localparam int INTERLEAVE_W = 5;
  localparam int SENSE_BYTES = 4;
  localparam logic [2:0] SENSE_LAST = 3'h3;
  localparam logic [7:0] MSG_OK = 8'h00;
  localparam logic [5:0] ERR_NOT_READY = 6'h04;
  localparam logic [5:0] ERR_NO_TRACK0 = 6'h06;
  localparam logic [5:0] ERR_SEEK = 6'h15;
  localparam logic [5:0] ERR_BAD_CMD = 6'h20;
  localparam logic [5:0] ERR_NONE = 6'h00;
  // Hash span and defect-map layout
  localparam int HASH_FIRST = 3;
  localparam int HASH_LAST = 255;
  localparam int HASH_COUNT = 253;
  localparam int ENTRY_BYTES = 4;
  localparam int MAX_ENTRIES = 63;
  localparam int FLAG_WHOLE_TRACK = 0;
  localparam int FLAG_BY_DIAG = 1;
  localparam int FLAG_BY_OS = 2;
  // Step pulse timing
  localparam int STEP_NS = 200;
  localparam int CLK_NS = 8;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] MAX_STEPS = 12'hFFF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STEP = 3'b001,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b010,
    ST_SENSE = 3'b110
  } dcs_state_t;
endpackage

// ### rtl/dcs_unit.sv
// Purpose: Command interpreter for test-ready, recalibrate, sense and format start
// Assumes: Host presents a whole six-byte string with cmd_valid; drive lines synchronous
// Notes: Defect-map helpers are combinational outputs registered for the host
// Function
// R1 - Defect-map sector hash covers bytes 3 to 255, 253 bytes
// R2 - Defect entry: three track bytes MSB first, then error flag byte
// R3 - Linear track equals cylinder times head count plus head
// R4 - Flag bit0 whole track, bit1 diagnostics, bit2 operating system, bit3 unused
// R5 - Opcode 00 selects the addressed drive and tests readiness
// R6 - Selected unit decides drive operated on; its state goes in completion
// R7 - Good status clears error flag with message 00, else flag and code
// R8 - Opcode 01 steps one cylinder at a time until track zero
// R9 - Error with retry bit set triggers automatic recalibration; code does so only for completion errors of a ready drive
// R10 - Host uses recalibrate only to fix positioning errors
// R11 - Opcode 03 returns exactly four status bytes
// R12 - Host may sense after a completion reporting an error
// R13 - After transfer error, sense bytes 1-3 hold failed address, unit in byte 1
// R14 - After good format or check, address points one sector past last track
// R15 - After failed format or check, address names the failing sector
// R16 - Sense byte 0: valid bit 7, zero bit 6, code bits 5-0
// R17 - Valid bit is zero when failed command used no block address
// R18 - Format drive covers given sector through maximum cylinder with interleave
// R19 - Sector header: 24-bit hash LSB first, then entry count
// R20 - Sector holds header plus up to 63 entries
// R21 - Unused command bytes are ignored
`timescale 1ns/10ps
`default_nettype none
module dcs_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [47:0] cmd_bytes,
  input wire logic [3:0] drive_ready,
  input wire logic [3:0] drive_fault,
  input wire logic [3:0] track_zero,
  input wire logic xfer_error,
  input wire logic [5:0] xfer_error_code,
  input wire logic [20:0] xfer_error_lsn,
  input wire logic [20:0] format_next_lsn,
  input wire logic [15:0] cylinder,
  input wire logic [7:0] head,
  input wire logic [7:0] head_count,
  input wire logic [7:0] map_flag_in,
  input wire logic sense_ack,
  output logic cmd_busy,
  output logic done,
  output logic done_error,
  output logic [7:0] done_msg,
  output logic [1:0] drive_unit_select,
  output logic step_out,
  output logic sense_valid,
  output logic [7:0] sense_byte,
  output logic format_start,
  output logic [20:0] format_lsn,
  output logic [4:0] format_interleave,
  output logic [23:0] linear_track,
  output logic [31:0] map_entry,
  output logic [2:0] map_flag_kind
);
  dcs_pkg::dcs_state_t state, next_state;
  logic [7:0] opcode, next_opcode;
  logic [1:0] next_unit;
  logic retry, next_retry;
  logic [11:0] steps, next_steps;
  logic [7:0] tick, next_tick;
  logic [5:0] err_code, next_err_code;
  logic addr_valid, next_addr_valid;
  logic [20:0] err_lsn, next_err_lsn;
  logic [2:0] sidx, next_sidx;
  logic next_done, next_done_error, next_step, next_fstart, next_sense_valid;
  logic [7:0] next_done_msg, next_sense_byte;
  logic [20:0] next_format_lsn;
  logic [4:0] next_format_il;
  logic next_busy;

  function automatic logic [1:0] unit_of(input logic [7:0] b1);
    unit_of = b1[dcs_pkg::UNIT_HI:dcs_pkg::UNIT_LO];
  endfunction

  function automatic logic [7:0] sense_at(input logic [2:0] i, input logic v,
      input logic [5:0] c, input logic [1:0] u, input logic [20:0] a);
    case (i)
      3'h0: sense_at = {v, 1'b0, c}; // [R16]
      3'h1: sense_at = {1'b0, u, a[20:16]}; // [R13]
      3'h2: sense_at = a[15:8];
      default: sense_at = a[7:0];
    endcase
  endfunction

  always_comb begin
    next_state = state;
    next_opcode = opcode;
    next_unit = drive_unit_select;
    next_retry = retry;
    next_steps = steps;
    next_tick = tick;
    next_err_code = err_code;
    next_addr_valid = addr_valid;
    next_err_lsn = err_lsn;
    next_sidx = sidx;
    next_done = 1'b0;
    next_done_error = done_error;
    next_done_msg = done_msg;
    next_step = 1'b0;
    next_fstart = 1'b0;
    next_sense_valid = sense_valid;
    next_sense_byte = sense_byte;
    next_format_lsn = format_lsn;
    next_format_il = format_interleave;
    case (state)
      dcs_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          // Opcode, unit and retry bits are read, plus address and interleave for format drive; the rest is ignored [R21]
          next_opcode = cmd_bytes[47:40];
          next_unit = unit_of(cmd_bytes[39:32]); // [R6]
          next_retry = cmd_bytes[dcs_pkg::RETRY_BIT];
          case (cmd_bytes[47:40])
            dcs_pkg::OP_TEST_READY: begin
              next_state = dcs_pkg::ST_DONE; // [R5]
            end
            dcs_pkg::OP_RECAL: begin
              next_steps = '0;
              next_state = dcs_pkg::ST_STEP;
            end
            dcs_pkg::OP_SENSE: begin
              next_sidx = '0;
              next_sense_valid = 1'b1;
              next_sense_byte = sense_at(3'h0, addr_valid, err_code, drive_unit_select,
                  err_lsn);
              next_state = dcs_pkg::ST_SENSE;
            end
            dcs_pkg::OP_FORMAT_DRIVE: begin
              next_fstart = 1'b1; // [R18]
              next_format_lsn = cmd_bytes[36:16];
              next_format_il = cmd_bytes[12:8];
              next_done_error = 1'b0;
              next_done_msg = dcs_pkg::MSG_OK;
              next_done = 1'b1;
            end
            default: begin
              next_err_code = dcs_pkg::ERR_BAD_CMD;
              next_addr_valid = 1'b0; // [R17]
              next_done_error = 1'b1;
              next_done_msg = {2'b00, dcs_pkg::ERR_BAD_CMD};
              next_done = 1'b1;
            end
          endcase
        end else if (format_next_lsn != format_lsn && !xfer_error) begin
          // Good format progress: address one sector past the last track done [R14]
          next_format_lsn = format_next_lsn;
          next_err_lsn = format_next_lsn;
        end
      end
      dcs_pkg::ST_STEP: begin
        if (track_zero[drive_unit_select]) begin
          next_state = dcs_pkg::ST_DONE; // [R8]
        end else if (steps == dcs_pkg::MAX_STEPS) begin
          next_state = dcs_pkg::ST_DONE;
        end else begin
          next_step = 1'b1; // [R8]
          next_steps = steps + 12'h001;
          next_tick = 8'(dcs_pkg::STEP_CYC);
          next_state = dcs_pkg::ST_WAIT;
        end
      end
      dcs_pkg::ST_WAIT: begin
        next_step = tick != 8'h00;
        next_tick = tick - 8'h01;
        if (tick == 8'h00) next_state = dcs_pkg::ST_STEP;
      end
      dcs_pkg::ST_DONE: begin
        next_done = 1'b1;
        if (!drive_ready[drive_unit_select] || drive_fault[drive_unit_select] ||
            (opcode == dcs_pkg::OP_RECAL && !track_zero[drive_unit_select])) begin
          next_err_code = !drive_ready[drive_unit_select] ? dcs_pkg::ERR_NOT_READY :
              (opcode == dcs_pkg::OP_RECAL ? dcs_pkg::ERR_NO_TRACK0 : dcs_pkg::ERR_SEEK);
          next_addr_valid = 1'b0; // [R17]
          next_done_error = 1'b1; // [R7]
          next_done_msg = {2'b00, next_err_code};
          // Retry enabled: recover head position automatically once [R9]
          if (retry && opcode != dcs_pkg::OP_RECAL && drive_ready[drive_unit_select]) begin
            next_done = 1'b0;
            next_opcode = dcs_pkg::OP_RECAL;
            next_steps = '0;
            next_state = dcs_pkg::ST_STEP;
          end else begin
            next_state = dcs_pkg::ST_IDLE;
          end
        end else begin
          next_err_code = dcs_pkg::ERR_NONE;
          next_done_error = 1'b0; // [R7]
          next_done_msg = dcs_pkg::MSG_OK;
          next_state = dcs_pkg::ST_IDLE;
        end
      end
      dcs_pkg::ST_SENSE: begin
        if (sense_ack) begin
          if (sidx == dcs_pkg::SENSE_LAST) begin
            next_sense_valid = 1'b0; // [R11]
            next_done_error = 1'b0;
            next_done_msg = dcs_pkg::MSG_OK;
            next_done = 1'b1;
            next_state = dcs_pkg::ST_IDLE;
          end else begin
            next_sidx = sidx + 3'h1;
            next_sense_byte = sense_at(sidx + 3'h1, addr_valid, err_code,
                drive_unit_select, err_lsn);
          end
        end
      end
      default: next_state = dcs_pkg::ST_IDLE;
    endcase
    // Latched last, so a new transfer error wins over a same-cycle clear
    if (xfer_error) begin
      next_err_code = xfer_error_code;
      next_addr_valid = 1'b1;
      next_err_lsn = xfer_error_lsn; // [R13] [R15]
    end
    next_busy = next_state != dcs_pkg::ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dcs_pkg::ST_IDLE;
      opcode <= 8'h00;
      drive_unit_select <= 2'h0;
      retry <= 1'b0;
      steps <= 12'h000;
      tick <= 8'h00;
      err_code <= 6'h00;
      addr_valid <= 1'b0;
      err_lsn <= 21'h000000;
      sidx <= 3'h0;
      done <= 1'b0;
      done_error <= 1'b0;
      done_msg <= 8'h00;
      step_out <= 1'b0;
      format_start <= 1'b0;
      sense_valid <= 1'b0;
      sense_byte <= 8'h00;
      format_lsn <= 21'h000000;
      format_interleave <= 5'h00;
      cmd_busy <= 1'b0;
    end else begin
      state <= next_state;
      opcode <= next_opcode;
      drive_unit_select <= next_unit;
      retry <= next_retry;
      steps <= next_steps;
      tick <= next_tick;
      err_code <= next_err_code;
      addr_valid <= next_addr_valid;
      err_lsn <= next_err_lsn;
      sidx <= next_sidx;
      done <= next_done;
      done_error <= next_done_error;
      done_msg <= next_done_msg;
      step_out <= next_step;
      format_start <= next_fstart;
      sense_valid <= next_sense_valid;
      sense_byte <= next_sense_byte;
      format_lsn <= next_format_lsn;
      format_interleave <= next_format_il;
      cmd_busy <= next_busy;
    end
  end

  // Defect-map helpers; host computes the hash over its 253-byte span [R1] [R19] [R20]
  logic [23:0] next_linear;
  logic [31:0] next_entry;
  logic [2:0] next_kind;
  always_comb begin
    next_linear = 24'(cylinder) * 24'(head_count) + 24'(head); // [R3]
    next_entry = {next_linear, map_flag_in}; // [R2]
    next_kind = {map_flag_in[dcs_pkg::FLAG_BY_OS], map_flag_in[dcs_pkg::FLAG_BY_DIAG],
        map_flag_in[dcs_pkg::FLAG_WHOLE_TRACK]}; // [R4]
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      linear_track <= 24'h000000;
      map_entry <= 32'h00000000;
      map_flag_kind <= 3'h0;
    end else begin
      linear_track <= next_linear;
      map_entry <= next_entry;
      map_flag_kind <= next_kind;
    end
  end

  sequence s_sense_start;
    state == dcs_pkg::ST_IDLE && cmd_valid && cmd_bytes[47:40] == dcs_pkg::OP_SENSE;
  endsequence
  a_sense_first_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_sense_start |=> sense_valid && sense_byte[6] == 1'b0) // [R16]
    else $error("sense byte 0 bit 6 not zero or not valid");
  a_sense_four_bytes: assert property (@(posedge core_clk) disable iff (!rst_n)
      sense_valid && sense_ack && sidx == 3'h3 |=> !sense_valid && done) // [R11]
    else $error("sense did not end after four bytes");
  a_ready_ok: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_DONE && opcode == dcs_pkg::OP_TEST_READY &&
      drive_ready[drive_unit_select] && !drive_fault[drive_unit_select]
      |=> done && !done_error && done_msg == 8'h00) // [R7]
    else $error("good ready test gave error");
  a_ready_bad: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_DONE && !drive_ready[drive_unit_select]
      |=> done && done_error && done_msg != 8'h00) // [R7]
    else $error("not ready drive gave no error");
  a_ready_path: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_IDLE && cmd_valid && cmd_bytes[47:40] == 8'h00
      |=> state == dcs_pkg::ST_DONE && drive_unit_select == $past(cmd_bytes[38:37])) // [R5] [R6]
    else $error("ready test did not select the unit");
  a_recal_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_STEP && track_zero[drive_unit_select]
      |=> !step_out && state == dcs_pkg::ST_DONE) // [R8]
    else $error("stepping past track zero");
  a_recal_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_STEP && !track_zero[drive_unit_select] && steps != 12'hFFF
      |=> step_out ##[1:30] state == dcs_pkg::ST_STEP) // [R8]
    else $error("step pulse missing");
  a_retry_recal: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_DONE && retry && opcode != dcs_pkg::OP_RECAL &&
      drive_ready[drive_unit_select] && drive_fault[drive_unit_select]
      |=> state == dcs_pkg::ST_STEP && opcode == dcs_pkg::OP_RECAL) // [R9]
    else $error("retry did not recalibrate");
  a_format_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
      state == dcs_pkg::ST_IDLE && cmd_valid && cmd_bytes[47:40] == 8'h04
      |=> format_start && format_interleave == $past(cmd_bytes[12:8])) // [R18]
    else $error("format start wrong");
  a_linear_track: assert property (@(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> linear_track ==
      24'($past(cylinder)) * 24'($past(head_count)) + 24'($past(head))) // [R3]
    else $error("linear track mismatch");
endmodule
`default_nettype wire

// ### sim/dcs_drive_model.sv
// Purpose: Behavioural model of four drives seen by the command unit
// Assumes: One step pulse moves the selected arm one cylinder toward zero
// Notes: Ready and fault levels are set by the bench; arm position is loadable
`timescale 1ns/10ps
`default_nettype none
module dcs_drive_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic step_out,
  input wire logic [1:0] drive_unit_select,
  input wire logic load,
  input wire logic [7:0] load_pos,
  input wire logic [3:0] ready_set,
  input wire logic [3:0] fault_set,
  output logic [3:0] drive_ready,
  output logic [3:0] drive_fault,
  output logic [3:0] track_zero
);
  logic [7:0] pos [4];
  logic step_q;
  // Edge detect, so a long step level counts once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'h0;
      for (int i = 0; i < 4; i++) pos[i] <= 8'h00;
    end else begin
      step_q <= step_out;
      if (load) begin
        for (int i = 0; i < 4; i++) pos[i] <= load_pos;
      end else if (step_out && !step_q && pos[drive_unit_select] != 8'h00) begin
        pos[drive_unit_select] <= pos[drive_unit_select] - 8'h01;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) track_zero[i] = (pos[i] == 8'h00);
  end
  assign drive_ready = ready_set;
  assign drive_fault = fault_set;
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the disk command and status unit
// Assumes: Drive model answers step pulses; inputs change 1 ns after the edge
// Notes: Random values from a 16-bit shift register seeded at 40741
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic cmd_valid = 1'h0;
  logic [47:0] cmd_bytes = 48'h0;
  logic [3:0] drive_ready, drive_fault, track_zero;
  logic [3:0] rdy = 4'hF;
  logic [3:0] flt = 4'h0;
  logic load = 1'h0;
  logic [7:0] load_pos = 8'h00;
  logic xfer_error = 1'h0;
  logic [5:0] xfer_error_code = 6'h00;
  logic [20:0] xfer_error_lsn = 21'h0;
  logic [20:0] format_next_lsn = 21'h0;
  logic [15:0] cylinder = 16'h0;
  logic [7:0] head = 8'h00;
  logic [7:0] head_count = 8'h00;
  logic [7:0] map_flag_in = 8'h00;
  logic sense_ack = 1'h0;
  logic cmd_busy, done, done_error, step_out, sense_valid, format_start, stq;
  logic [7:0] done_msg, sense_byte;
  logic [1:0] drive_unit_select, u;
  logic [20:0] format_lsn, a;
  logic [4:0] format_interleave;
  logic [23:0] linear_track;
  logic [31:0] map_entry, sb;
  logic [2:0] map_flag_kind;
  logic [15:0] seed;
  logic [7:0] b;
  logic [5:0] c;
  int n_fail = 0;
  int checked = 0;
  int n_steps = 0;
  always #4 core_clk = ~core_clk;
  dcs_unit dut_u (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_bytes(cmd_bytes), .drive_ready(drive_ready), .drive_fault(drive_fault),
    .track_zero(track_zero), .xfer_error(xfer_error), .xfer_error_code(xfer_error_code),
    .xfer_error_lsn(xfer_error_lsn), .format_next_lsn(format_next_lsn),
    .cylinder(cylinder), .head(head), .head_count(head_count), .map_flag_in(map_flag_in),
    .sense_ack(sense_ack), .cmd_busy(cmd_busy), .done(done), .done_error(done_error),
    .done_msg(done_msg), .drive_unit_select(drive_unit_select), .step_out(step_out),
    .sense_valid(sense_valid), .sense_byte(sense_byte), .format_start(format_start),
    .format_lsn(format_lsn), .format_interleave(format_interleave),
    .linear_track(linear_track), .map_entry(map_entry), .map_flag_kind(map_flag_kind));
  dcs_drive_model drv_u (.core_clk(core_clk), .rst_n(rst_n), .step_out(step_out),
    .drive_unit_select(drive_unit_select), .load(load), .load_pos(load_pos),
    .ready_set(rdy), .fault_set(flt), .drive_ready(drive_ready),
    .drive_fault(drive_fault), .track_zero(track_zero));
  // Count step pulses by their rising edge
  always @(posedge core_clk) begin
    if (step_out === 1'h1 && stq !== 1'h1) n_steps++;
    stq = step_out;
  end
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [47:0] mk(input logic [7:0] op, input logic [1:0] uu,
      input logic [20:0] aa, input logic [7:0] bb, input logic r);
    return {op, 1'h0, uu, aa, bb, r, 7'h00};
  endfunction
  function automatic logic [7:0] exp_msg(input logic r, input logic f);
    if (!r) return {2'h0, dcs_pkg::ERR_NOT_READY};
    if (f) return {2'h0, dcs_pkg::ERR_SEEK};
    return dcs_pkg::MSG_OK;
  endfunction
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic send(input logic [47:0] cb);
    cmd_valid = 1'h1;
    cmd_bytes = cb;
    tick();
    cmd_valid = 1'h0;
  endtask
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while (done !== 1'h1 && k < lim) begin
      tick();
      k++;
    end
    chk("done", 1'h1, done);
  endtask
  task automatic sense(input logic [1:0] uu);
    int k;
    send(mk(dcs_pkg::OP_SENSE, uu, 21'(rnd()), 8'(rnd()), 1'h0));
    k = 0;
    while (sense_valid !== 1'h1 && k < 20) begin
      tick();
      k++;
    end
    chk("busy", 1'h1, cmd_busy);
    for (int j = 0; j < 4; j++) begin
      chk("sense_valid", 1'h1, sense_valid);
      sb = {sb[23:0], sense_byte};
      sense_ack = 1'h1;
      tick();
    end
    sense_ack = 1'h0;
    wait_done(3);
    chk("sense_over", 1'h0, sense_valid);
    chk("idle", 1'h0, cmd_busy);
  endtask
  task automatic recal_case(input logic [7:0] p, input logic [7:0] op, input logic r);
    load = 1'h1;
    load_pos = p;
    tick();
    load = 1'h0;
    n_steps = 0;
    send(mk(op, u, 21'(rnd()), 8'(rnd()), r));
    wait_done(3000);
  endtask
  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    seed = 16'h9F25;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'h1;
    for (int i = 0; i < 20; i++) begin
      cylinder = rnd();
      head = 8'(rnd());
      head_count = 8'(rnd());
      map_flag_in = 8'(rnd());
      tick();
      tick();
      sb = 32'(cylinder) * 32'(head_count) + 32'(head);
      chk("track", sb, linear_track);
      chk("entry", {sb[23:0], map_flag_in}, map_entry);
      chk("kind", map_flag_in[2:0], map_flag_kind);
    end
    // Mixed ready and fault levels; unused bytes carry noise
    for (int i = 0; i < 10; i++) begin
      u = 2'(rnd());
      rdy = (i == 0) ? 4'hF : 4'(rnd());
      flt = (i == 0) ? 4'h0 : 4'(rnd());
      send(mk(dcs_pkg::OP_TEST_READY, u, 21'(rnd()), 8'(rnd()), 1'h0));
      wait_done(40);
      chk("unit", u, drive_unit_select);
      chk("err", !rdy[u] || flt[u], done_error);
      chk("msg", exp_msg(rdy[u], flt[u]), done_msg);
      tick();
    end
    rdy = 4'h0;
    u = 2'h2;
    send(mk(dcs_pkg::OP_TEST_READY, u, 21'h0, 8'h00, 1'h0));
    wait_done(40);
    sense(u);
    chk("b0_top", 2'h0, sb[31:30]);
    chk("b0_code", dcs_pkg::ERR_NOT_READY, sb[29:24]);
    rdy = 4'hF;
    flt = 4'h0;
    a = 21'(rnd());
    b = 8'(rnd()) & 8'h1F;
    u = 2'h1;
    send(mk(dcs_pkg::OP_FORMAT_DRIVE, u, a, b, 1'h0));
    wait_done(5);
    chk("fstart", 1'h1, format_start);
    chk("flsn", a, format_lsn);
    chk("fil", b[4:0], format_interleave);
    format_next_lsn = a + 21'h20;
    tick();
    sense(u);
    chk("next_lsn", {1'h0, u, format_next_lsn}, sb[23:0]);
    c = 6'(rnd()) | 6'h01;
    xfer_error_code = c;
    xfer_error_lsn = 21'(rnd());
    xfer_error = 1'h1;
    tick();
    xfer_error = 1'h0;
    sense(u);
    chk("err_sense", {1'h1, 1'h0, c, 1'h0, u, xfer_error_lsn}, sb);
    send(mk(8'h3F, u, 21'h0, 8'h00, 1'h0));
    wait_done(5);
    chk("bad_op", {1'h1, 2'h0, dcs_pkg::ERR_BAD_CMD}, {done_error, done_msg});
    // Arm already home, short and long walks
    for (int i = 0; i < 4; i++) begin
      u = 2'(i);
      b = (i == 0) ? 8'h00 : (i == 3) ? 8'h0C : 8'((rnd() & 16'h7) + 16'h1);
      recal_case(b, dcs_pkg::OP_RECAL, 1'h0);
      chk("steps", b, n_steps);
      chk("recal_err", 1'h0, done_error);
    end
    u = 2'h3;
    flt = 4'h8;
    recal_case(8'h03, dcs_pkg::OP_TEST_READY, 1'h1);
    chk("retry_steps", 32'h3, n_steps);
    chk("retry_err", 1'h1, done_error);
    recal_case(8'h03, dcs_pkg::OP_TEST_READY, 1'h0);
    chk("noretry_steps", 32'h0, n_steps);
    report_and_stop();
  end
endmodule
`default_nettype wire
